// ==== logic/rcmc_pkg.sv ====
// Constants, register map and state codes of the reset-cause and mode control block.
// Assumes one 20 MHz system clock and an AXI4-Lite register bus with 8-bit byte addresses.
package rcmc_pkg;

    // ==========================================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned WARMUP_NS     = 100000;
    localparam int unsigned WARMUP_CYC    = (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] WARMUP_CNT    = 12'(WARMUP_CYC);

    // ==========================================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CAUSE   = 8'hF0;
    localparam logic [7:0] ADDR_STOPCTL = 8'hF4;
    localparam logic [7:0] ADDR_STATUS  = 8'hF8;
    localparam logic [7:0] ADDR_OPTION  = 8'hFC;

    // ==========================================================================
    // Field positions and values
    localparam int unsigned CAUSE_PIN   = 4;
    localparam int unsigned CAUSE_KEYIN = 3;
    localparam int unsigned CAUSE_WDT   = 2;
    localparam int unsigned CAUSE_LVD   = 1;
    localparam int unsigned CAUSE_POR   = 0;
    localparam logic [4:0]  CAUSE_RST   = 5'h03;
    localparam logic [4:0]  CAUSE_NONE  = 5'h00;
    localparam logic [7:0]  STOP_KEY    = 8'hA5;
    localparam logic [7:0]  STOPCTL_RST = 8'h00;
    localparam int unsigned STAT_PPIN   = 2;
    localparam int unsigned STAT_PLVD   = 3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==========================================================================
    // Types
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_BACKUP = 2'b01,
        ST_WARMUP = 2'b10,
        ST_STOP   = 2'b11
    } rcmc_state_e;

    typedef enum logic [2:0] {
        REG_CAUSE   = 3'b000,
        REG_STOPCTL = 3'b001,
        REG_STATUS  = 3'b010,
        REG_OPTION  = 3'b011,
        REG_NONE    = 3'b100
    } rcmc_reg_e;

endpackage

// ==== logic/rcmc_top.sv ====
// Reset-cause flags, backup/reset/stop mode sequencer and its AXI4-Lite registers.
// Assumes all inputs synchronous to clk_i; nrst_i is the power-on reset of the chip.
`timescale 1ns/100ps

module rcmc_top (
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  ext_reset_pin_i,
    input  wire logic                  supply_low_i,
    input  wire logic                  wdt_overflow_i,
    input  wire logic                  stop_instr_i,
    input  wire logic                  ext_int_i,
    input  wire logic                  stop_release_i,
    output logic                       cpu_reset_o,
    output logic                       port_float_o,
    output logic                       port_input_block_o,
    output logic                       pullup_off_o,
    output logic                       port_hold_o,
    output logic                       stop_mode_o,
    input  wire logic [7:0]            s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [7:0]            s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i
);
    import rcmc_pkg::*;

    // ==========================================================================
    // Address decode
    function automatic rcmc_reg_e decode(input logic [7:0] addr);
        unique case (addr)
            ADDR_CAUSE:   decode = REG_CAUSE;
            ADDR_STOPCTL: decode = REG_STOPCTL;
            ADDR_STATUS:  decode = REG_STATUS;
            ADDR_OPTION:  decode = REG_OPTION;
            default:      decode = REG_NONE;
        endcase
    endfunction

    // ==========================================================================
    // Mode sequencer
    rcmc_state_e state_q, state_d;
    logic [11:0] warm_q, warm_d;
    logic        pend_pin_q, pend_pin_d, pend_lvd_q, pend_lvd_d;
    logic [4:0]  cause_set, cause_keep, cause_q, cause_d;
    logic        backup_cond, stop_enter;
    logic [7:0]  stopctl_q, stopctl_d;
    logic        option_q, option_d;
    assign backup_cond = !ext_reset_pin_i || supply_low_i;
    assign stop_enter  = stop_instr_i && (stopctl_q == STOP_KEY);
    always_comb begin
        state_d    = state_q;
        warm_d     = warm_q;
        pend_pin_d = pend_pin_q;
        pend_lvd_d = pend_lvd_q;
        cause_set  = CAUSE_NONE;
        cause_keep = 5'h1F;
        if (backup_cond) begin
            state_d    = ST_BACKUP;
            pend_pin_d = pend_pin_q || !ext_reset_pin_i;
            pend_lvd_d = pend_lvd_q || supply_low_i;
        end else begin
            unique case (state_q)
                ST_BACKUP: begin
                    state_d    = ST_WARMUP;
                    warm_d     = '0;
                    pend_pin_d = 1'b0;
                    pend_lvd_d = 1'b0;
                    if (pend_lvd_q) begin
                        cause_keep = 5'h01;
                        cause_set[CAUSE_LVD] = 1'b1;
                    end else begin
                        cause_keep = 5'h03;
                        cause_set[CAUSE_PIN] = 1'b1;
                        cause_set[CAUSE_WDT] = wdt_overflow_i;
                    end
                end
                ST_WARMUP: begin
                    if (warm_q == WARMUP_CNT - 12'h001) begin
                        state_d = ST_RUN;
                    end else begin
                        warm_d = warm_q + 12'h001;
                    end
                end
                ST_RUN: begin
                    if (wdt_overflow_i) begin
                        state_d    = ST_WARMUP;
                        warm_d     = '0;
                        cause_keep = 5'h03;
                        cause_set[CAUSE_WDT] = 1'b1;
                    end else if (stop_enter) begin
                        state_d = ST_STOP;
                    end
                end
                ST_STOP: begin
                    // The watchdog does not wake the chip from stop.
                    if (ext_int_i || stop_release_i) begin
                        if (option_q) begin
                            state_d = ST_RUN;
                        end else begin
                            state_d    = ST_WARMUP;
                            warm_d     = '0;
                            cause_keep = 5'h03;
                            cause_set[CAUSE_KEYIN] = 1'b1;
                        end
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ST_WARMUP;
            warm_q     <= '0;
            pend_pin_q <= 1'b0;
            pend_lvd_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            warm_q     <= warm_d;
            pend_pin_q <= pend_pin_d;
            pend_lvd_q <= pend_lvd_d;
        end
    end

    // ==========================================================================
    // Port and core control outputs, registered from the next state
    logic cpu_reset_d, float_d, block_d, hold_d;
    always_comb begin
        cpu_reset_d = (state_d == ST_BACKUP) || (state_d == ST_WARMUP);
        float_d     = cpu_reset_d;
        block_d     = (state_d == ST_BACKUP);
        hold_d      = (state_d == ST_STOP);
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cpu_reset_o        <= 1'b1;
            port_float_o       <= 1'b1;
            port_input_block_o <= 1'b0;
            pullup_off_o       <= 1'b1;
            port_hold_o        <= 1'b0;
            stop_mode_o        <= 1'b0;
        end else begin
            cpu_reset_o        <= cpu_reset_d;
            port_float_o       <= float_d;
            port_input_block_o <= block_d;
            pullup_off_o       <= float_d;
            port_hold_o        <= hold_d;
            stop_mode_o        <= hold_d;
        end
    end

    // ==========================================================================
    // AXI4-Lite slave and registers
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]  bresp_d, rresp_d;
    logic        do_write, cause_wr0;
    rcmc_reg_e   wsel, rsel;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid_o;
    assign wsel     = decode(awaddr_q);
    assign rsel     = decode(s_axi_araddr_i);
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = s_axi_bvalid_o && !s_axi_bready_i;
        bresp_d   = s_axi_bresp_o;
        rvalid_d  = s_axi_rvalid_o && !s_axi_rready_i;
        rdata_d   = s_axi_rdata_o;
        rresp_d   = s_axi_rresp_o;
        cause_d   = cause_q;
        stopctl_d = stopctl_q;
        option_d  = option_q;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata_i;
            wstrb_d  = s_axi_wstrb_i;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wstrb_q[0]) begin
                unique case (wsel)
                    REG_CAUSE:   cause_d = cause_q & wdata_q[4:0];
                    REG_STOPCTL: stopctl_d = wdata_q[7:0];
                    REG_OPTION:  option_d = wdata_q[0];
                    REG_STATUS:  ;
                    REG_NONE:    ;
                endcase
            end
        end
        // A hardware set lands after the software clear, so an event is never lost.
        cause_d = (cause_d & cause_keep) | cause_set;
        if (cpu_reset_d) begin
            stopctl_d = STOPCTL_RST;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = '0;
            unique case (rsel)
                REG_CAUSE:   rdata_d[4:0] = cause_q;
                REG_STOPCTL: rdata_d[7:0] = stopctl_q;
                REG_OPTION:  rdata_d[0] = option_q;
                REG_STATUS: begin
                    rdata_d[1:0]      = state_q;
                    rdata_d[STAT_PPIN] = pend_pin_q;
                    rdata_d[STAT_PLVD] = pend_lvd_q;
                end
                REG_NONE:    rresp_d = RESP_SLVERR;
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_have_q       <= 1'b0;
            w_have_q        <= 1'b0;
            awaddr_q        <= '0;
            wdata_q         <= '0;
            wstrb_q         <= '0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= RESP_OKAY;
            cause_q         <= CAUSE_RST;
            stopctl_q       <= STOPCTL_RST;
            option_q        <= 1'b0;
        end else begin
            aw_have_q       <= aw_have_d;
            w_have_q        <= w_have_d;
            awaddr_q        <= awaddr_d;
            wdata_q         <= wdata_d;
            wstrb_q         <= wstrb_d;
            s_axi_awready_o <= awready_d;
            s_axi_wready_o  <= wready_d;
            s_axi_bvalid_o  <= bvalid_d;
            s_axi_bresp_o   <= bresp_d;
            s_axi_arready_o <= arready_d;
            s_axi_rvalid_o  <= rvalid_d;
            s_axi_rdata_o   <= rdata_d;
            s_axi_rresp_o   <= rresp_d;
            cause_q         <= cause_d;
            stopctl_q       <= stopctl_d;
            option_q        <= option_d;
        end
    end

    // ==========================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    assign cause_wr0 = do_write && wsel == REG_CAUSE && wstrb_q[0];
    a_backup_ports: assert property (backup_cond |=> state_q == ST_BACKUP ##0 port_float_o
        && port_input_block_o && pullup_off_o && cpu_reset_o)
        else $error("Backup did not float and block the ports.");
    a_reset_float: assert property (state_q == ST_WARMUP |-> port_float_o && pullup_off_o
        && !port_input_block_o && cpu_reset_o)
        else $error("Reset state left ports driven or pull-ups on.");
    a_pin_flag: assert property (state_q == ST_BACKUP && !backup_cond && !pend_lvd_q
        |=> state_q == ST_WARMUP && cause_q[CAUSE_PIN] && !cause_q[CAUSE_KEYIN]
        && cause_q[1:0] == $past(cause_q[1:0]))
        else $error("Pin reset did not mark its cause.");
    a_lvd_flag: assert property (state_q == ST_BACKUP && !backup_cond && pend_lvd_q
        |=> cause_q[4:1] == 4'h1 && cause_q[CAUSE_POR] == $past(cause_q[CAUSE_POR]))
        else $error("Supply-drop reset marked the wrong causes.");
    a_wdt_flag: assert property (state_q == ST_RUN && !backup_cond && wdt_overflow_i
        |=> state_q == ST_WARMUP && cause_q[4:2] == 3'h1 ##1 cpu_reset_o)
        else $error("Watchdog reset did not mark its cause.");
    a_warmup_len: assert property (state_q == ST_RUN && $past(state_q) == ST_WARMUP
        |-> $past(warm_q) == WARMUP_CNT - 12'h001)
        else $error("Reset state left before warm-up ended.");
    a_zero_clears: assert property (cause_wr0 && !wdata_q[CAUSE_WDT] && !cause_set[CAUSE_WDT]
        |=> !cause_q[CAUSE_WDT])
        else $error("Writing zero did not clear the flag.");
    a_one_keeps: assert property (cause_wr0 && wdata_q[4:0] == 5'h1F && cause_set == 5'h00
        && cause_keep == 5'h1F |=> $stable(cause_q))
        else $error("Writing ones changed the cause flags.");
    a_stop_hold: assert property (state_q == ST_RUN && !backup_cond && !wdt_overflow_i
        && stop_enter |=> state_q == ST_STOP ##1 port_hold_o && !port_float_o)
        else $error("Stop entry did not hold the ports.");
    a_stop_keyin: assert property (state_q == ST_STOP && !backup_cond && ext_int_i && !option_q
        |=> state_q == ST_WARMUP && cause_q[CAUSE_KEYIN] ##1 cpu_reset_o)
        else $error("Key-in release did not reset with its cause.");
    a_stop_wake: assert property (state_q == ST_STOP && !backup_cond && stop_release_i
        && option_q |=> state_q == ST_RUN ##1 !port_hold_o && !cpu_reset_o)
        else $error("Stop release did not resume running.");
endmodule

// ==== verif/rcmc_src_model.sv ====
// Model of the far side: external reset pin, supply detector, watchdog and wake sources.
// Assumes the bench commands each source by a level that is taken at the rising clock edge.
`timescale 1ns/100ps

module rcmc_src_model (
    input  wire logic clk_i,
    input  wire logic hold_pin_i,
    input  wire logic sag_i,
    input  wire logic wdt_i,
    input  wire logic key_i,
    input  wire logic rel_i,
    output logic      ext_reset_pin_o = 1'b1,
    output logic      supply_low_o    = 1'b0,
    output logic      wdt_overflow_o  = 1'b0,
    output logic      ext_int_o       = 1'b0,
    output logic      stop_release_o  = 1'b0
);
    // ==========================================================================
    // Source drivers
    // Unused port 1 and 2 pins are parked by software in port registers, not here.
    // The pin is a level; its rising edge is simply the end of a hold.
    always @(posedge clk_i) begin
        ext_reset_pin_o <= !hold_pin_i;
        supply_low_o    <= sag_i;
        wdt_overflow_o  <= wdt_i;
        ext_int_o       <= key_i;
        stop_release_o  <= rel_i;
    end
endmodule

// ==== verif/rcmc_top_tb.sv ====
// Self-checking bench for the reset-cause and mode control block.
// Assumes the design package and one 20 MHz clock; registers reached over AXI4-Lite.
`timescale 1ns/100ps

module rcmc_top_tb;
    import rcmc_pkg::*;
    logic clk = 1'b0, nrst_n = 1'b0, stp = 1'b0;
    logic hold = 1'b0, sag = 1'b0, wdt = 1'b0, key = 1'b0, rel = 1'b0;
    logic pin, low, wov, eint, srel;
    logic cpu_rst, flt, iblk, puoff, phold, smode;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_fail = 0, num_checks = 0, cyc = 0;

    rcmc_src_model i_rcmc_src_model (.clk_i(clk), .hold_pin_i(hold), .sag_i(sag),
        .wdt_i(wdt), .key_i(key), .rel_i(rel), .ext_reset_pin_o(pin), .supply_low_o(low),
        .wdt_overflow_o(wov), .ext_int_o(eint), .stop_release_o(srel));

    rcmc_top i_rcmc_top (.clk_i(clk), .nrst_i(nrst_n), .ext_reset_pin_i(pin),
        .supply_low_i(low), .wdt_overflow_i(wov), .stop_instr_i(stp), .ext_int_i(eint),
        .stop_release_i(srel), .cpu_reset_o(cpu_rst), .port_float_o(flt),
        .port_input_block_o(iblk), .pullup_off_o(puoff), .port_hold_o(phold),
        .stop_mode_o(smode), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    // ==========================================================================
    // Clock, timeout and verdict
    initial begin
        forever #25 clk = ~clk;
    end

    // Longest run is five warm-ups of 2000 cycles plus bus traffic.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ==========================================================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        // An idle edge keeps the next request from re-raising bready in this time step.
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
        chk(32'(r), 32'(RESP_OKAY));
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask

    // Called at the edge that starts the reset state; 2000 cycles of warm-up.
    task automatic warm();
        step(1990);
        chk(cpu_rst, 1'b1);
        step(20);
        chk(cpu_rst, 1'b0);
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_por();
        chk({flt, puoff, iblk}, 3'b110);
        warm();
        rd_chk(ADDR_CAUSE, 32'h03);
        rd_chk(ADDR_STATUS, 32'h0);
    endtask

    task automatic t_wdt();
        wdt <= 1'b1;
        step(1);
        wdt <= 1'b0;
        step(3);
        chk({cpu_rst, flt, puoff, iblk}, 4'b1110);
        warm();
        rd_chk(ADDR_CAUSE, 32'h07);
    endtask

    task automatic t_clear();
        wr_ok(ADDR_CAUSE, 32'h1F);
        rd_chk(ADDR_CAUSE, 32'h07);
        wr_ok(ADDR_CAUSE, 32'h1E);
        rd_chk(ADDR_CAUSE, 32'h06);
        wr_ok(ADDR_CAUSE, 32'h00);
        rd_chk(ADDR_CAUSE, 32'h00);
    endtask

    task automatic t_pin();
        wr_ok(ADDR_STOPCTL, 32'hA5);
        hold <= 1'b1;
        step(4);
        chk({cpu_rst, flt, iblk, puoff}, 4'b1111);
        rd_chk(ADDR_STATUS, 32'h05);
        hold <= 1'b0;
        wdt <= 1'b1;
        step(1);
        wdt <= 1'b0;
        step(2);
        chk({flt, iblk}, 2'b10);
        step(1987);
        chk(cpu_rst, 1'b1);
        step(20);
        chk(cpu_rst, 1'b0);
        rd_chk(ADDR_CAUSE, 32'h14);
        rd_chk(ADDR_STOPCTL, 32'h00);
    endtask

    task automatic t_drop();
        sag <= 1'b1;
        step(4);
        chk({cpu_rst, flt, iblk, puoff}, 4'b1111);
        rd_chk(ADDR_STATUS, 32'h09);
        sag <= 1'b0;
        warm();
        rd_chk(ADDR_CAUSE, 32'h02);
    endtask

    task automatic t_stop();
        wr_ok(ADDR_OPTION, 32'h1);
        wr_ok(ADDR_STOPCTL, 32'h00);
        stp <= 1'b1;
        step(1);
        stp <= 1'b0;
        step(3);
        chk(smode, 1'b0);
        wr_ok(ADDR_STOPCTL, 32'hA5);
        stp <= 1'b1;
        step(1);
        stp <= 1'b0;
        step(3);
        chk({smode, phold}, 2'b11);
        wdt <= 1'b1;
        step(1);
        wdt <= 1'b0;
        step(3);
        chk({smode, cpu_rst}, 2'b10);
        rel <= 1'b1;
        step(1);
        rel <= 1'b0;
        step(3);
        chk({smode, phold, cpu_rst}, 3'b000);
        wr_ok(ADDR_OPTION, 32'h0);
        wr_ok(ADDR_CAUSE, 32'h0);
        wr_ok(ADDR_STOPCTL, 32'hA5);
        stp <= 1'b1;
        step(1);
        stp <= 1'b0;
        step(3);
        key <= 1'b1;
        step(1);
        key <= 1'b0;
        step(2);
        chk({smode, cpu_rst, flt}, 3'b011);
        step(1988);
        chk(cpu_rst, 1'b1);
        step(20);
        chk(cpu_rst, 1'b0);
        rd_chk(ADDR_CAUSE, 32'h08);
    endtask

    task automatic t_bad();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h10, 32'hFF, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(8'h10, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        wstrb <= 4'hE;
        wr_ok(ADDR_CAUSE, 32'h00);
        wstrb <= 4'hF;
        rd_chk(ADDR_CAUSE, 32'h08);
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        step(2);
        nrst_n <= 1'b1;
        t_por();
        t_wdt();
        t_clear();
        t_pin();
        t_drop();
        t_stop();
        t_bad();
        summarize();
    end
endmodule
